// ===== logic/irq_bank_if.sv
`timescale 1ns/100ps
// one bank of sticky flags seen from the controller and from the bank
interface irq_bank_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] set_evt;
    logic [WIDTH-1:0] clr_req;
    logic [WIDTH-1:0] keep_mask;
    logic [WIDTH-1:0] enable;
    logic [WIDTH-1:0] flags;
    logic pend_any;
    modport bank (input set_evt, input clr_req, input keep_mask, input enable, output flags, output pend_any);
    modport ctl (output set_evt, output clr_req, output keep_mask, output enable, input flags, input pend_any);
endinterface

// ===== logic/irq_flag_bank.sv
`timescale 1ns/100ps
module irq_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    irq_bank_if.bank bank
);
    logic [WIDTH-1:0] flag_q;

    // ******************************************************
    // per-bit sticky flags
    // ******************************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_flag
        // an event in the clearing cycle wins, so nothing is lost
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                flag_q[i] <= 1'b0;
            end else if (ce) begin
                if (!bank.keep_mask[i]) begin
                    flag_q[i] <= 1'b0;
                end else if (bank.set_evt[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (bank.clr_req[i]) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    end

    // enabled flags fold into one pending term
    assign bank.flags = flag_q;
    assign bank.pend_any = |(flag_q & bank.enable & bank.keep_mask);
endmodule // irq_flag_bank

// ===== logic/meter_irq_pkg.sv
package meter_irq_pkg;

    typedef logic [7:0] byte_t;

    // ******************************************************
    // register addresses
    // ******************************************************
    localparam byte_t ADDR_ACCUM_MODE = 8'hD8;
    localparam byte_t ADDR_ENABLE_LOW = 8'hD9;
    localparam byte_t ADDR_ENABLE_MID = 8'hDA;
    localparam byte_t ADDR_ENABLE_HIGH = 8'hDB;
    localparam byte_t ADDR_STATUS_LOW = 8'hDC;
    localparam byte_t ADDR_STATUS_MID = 8'hDD;
    localparam byte_t ADDR_STATUS_HIGH = 8'hDE;

    // ******************************************************
    // field positions
    // ******************************************************
    localparam int SUMMARY_BIT = 7;
    localparam int REACT_SIGN_BIT = 4;
    localparam int ACT_SIGN_BIT = 3;
    localparam int APP_NOLOAD_BIT = 2;
    localparam int REACT_NOLOAD_BIT = 1;
    localparam int ACT_NOLOAD_BIT = 0;
    localparam int FREQ_B_BIT = 7;
    localparam int FREQ_A_BIT = 6;
    localparam int APP_OVF_BIT = 5;
    localparam int REACT_OVF_BIT = 4;
    localparam int ACT_OVF_BIT = 3;
    localparam int APP_HALF_BIT = 2;
    localparam int REACT_HALF_BIT = 1;
    localparam int ACT_HALF_BIT = 0;
    localparam int RESET_DONE_BIT = 7;
    localparam int WAVE_READY_BIT = 5;
    localparam int CUR_PEAK_BIT = 4;
    localparam int VOLT_PEAK_BIT = 3;
    localparam int CYCLE_DONE_BIT = 2;
    localparam int ZX_TIMEOUT_BIT = 1;
    localparam int ZX_BIT = 0;
    localparam int REACT_SIGN_DIR_BIT = 5;
    localparam int ACT_SIGN_DIR_BIT = 4;

    // ******************************************************
    // implemented-bit masks and reset values
    // ******************************************************
    localparam byte_t LOW_VALID_MASK = 8'h1F;
    localparam byte_t MID_VALID_MASK = 8'hFF;
    localparam byte_t HIGH_STATUS_MASK = 8'hBF;
    localparam byte_t HIGH_ENABLE_MASK = 8'h3F;
    localparam byte_t LOW_REACT_MASK = 8'h12;
    localparam byte_t MID_REACT_MASK = 8'h12;
    localparam byte_t ACCUM_MODE_MASK = 8'h30;
    localparam byte_t ENABLE_RESET = 8'h00;
    localparam byte_t ACCUM_MODE_RESET = 8'h00;
    localparam byte_t READ_IDLE = 8'h00;

endpackage

// ===== logic/metering_interrupt_flags.sv
`timescale 1ns/100ps
module metering_interrupt_flags #(
    parameter bit HAS_REACTIVE = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input meter_irq_pkg::byte_t reg_addr,
    input meter_irq_pkg::byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output meter_irq_pkg::byte_t reg_rdata,
    input wire logic power_sign_valid,
    input wire logic active_power_neg,
    input wire logic reactive_power_neg,
    input wire logic apparent_noload_flag,
    input wire logic irms_noload_enter,
    input wire logic reactive_noload_flag,
    input wire logic active_noload_flag,
    input wire logic freq_out_a_pulse,
    input wire logic freq_out_b_pulse,
    input wire logic apparent_energy_overflow,
    input wire logic reactive_energy_overflow,
    input wire logic active_energy_overflow,
    input wire logic apparent_energy_half,
    input wire logic reactive_energy_half,
    input wire logic active_energy_half,
    input wire logic soft_reset_done,
    input wire logic waveform_sample_ready,
    input wire logic current_peak_flag,
    input wire logic voltage_peak_flag,
    input wire logic cycle_accum_done,
    input wire logic zero_cross_timeout,
    input wire logic zero_cross_flag,
    output meter_irq_pkg::byte_t accumulation_mode_cfg,
    output logic meas_irq_pending
);
    import meter_irq_pkg::*;

    // ******************************************************
    // variant masks
    // ******************************************************
    // stripping the reactive bits here keeps them zero in flags and enables alike
    localparam byte_t LOW_KEEP = HAS_REACTIVE ? LOW_VALID_MASK : (LOW_VALID_MASK & ~LOW_REACT_MASK);
    localparam byte_t MID_KEEP = HAS_REACTIVE ? MID_VALID_MASK : (MID_VALID_MASK & ~MID_REACT_MASK);

    // ******************************************************
    // declarations
    // ******************************************************
    byte_t enable_low_q;
    byte_t enable_mid_q;
    byte_t enable_high_q;
    byte_t accum_mode_q;
    byte_t rdata_q;
    byte_t rdata_d;
    logic boot_seen_q;
    logic act_sign_chg;
    logic react_sign_chg;
    logic summary;
    logic wr_status_low;
    logic wr_status_mid;
    logic wr_status_high;

    irq_bank_if #(.WIDTH(8)) low_if ();
    irq_bank_if #(.WIDTH(8)) mid_if ();
    irq_bank_if #(.WIDTH(8)) high_if ();

    // ******************************************************
    // sign change detectors
    // ******************************************************
    // event sources share our clock, so their levels are read directly
    sign_change_detect u_act_sign (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .sample_valid(power_sign_valid),
        .sign_neg(active_power_neg),
        .rise_to_pos(accum_mode_q[ACT_SIGN_DIR_BIT]),
        .change_strobe(act_sign_chg)
    );

    sign_change_detect u_react_sign (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .sample_valid(power_sign_valid),
        .sign_neg(reactive_power_neg),
        .rise_to_pos(accum_mode_q[REACT_SIGN_DIR_BIT]),
        .change_strobe(react_sign_chg)
    );

    // ******************************************************
    // write decode
    // ******************************************************
    // writes are ignored while ce is low, matching the frozen state
    assign wr_status_low = ce && reg_wr && (reg_addr == ADDR_STATUS_LOW);
    assign wr_status_mid = ce && reg_wr && (reg_addr == ADDR_STATUS_MID);
    assign wr_status_high = ce && reg_wr && (reg_addr == ADDR_STATUS_HIGH);

    // enable registers, reserved bits held at zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_low_q <= ENABLE_RESET;
            enable_mid_q <= ENABLE_RESET;
            enable_high_q <= ENABLE_RESET;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                ADDR_ENABLE_LOW: enable_low_q <= reg_wdata & LOW_KEEP;
                ADDR_ENABLE_MID: enable_mid_q <= reg_wdata & MID_KEEP;
                ADDR_ENABLE_HIGH: enable_high_q <= reg_wdata & HIGH_ENABLE_MASK;
                default: ;
            endcase
        end
    end

    // local copy of the sign direction selects
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accum_mode_q <= ACCUM_MODE_RESET;
        end else if (ce && reg_wr && (reg_addr == ADDR_ACCUM_MODE)) begin
            accum_mode_q <= reg_wdata & ACCUM_MODE_MASK;
        end
    end

    assign accumulation_mode_cfg = accum_mode_q;

    // ******************************************************
    // end of reset event
    // ******************************************************
    // the first enabled cycle after release raises the reset flag once
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_seen_q <= 1'b0;
        end else if (ce) begin
            boot_seen_q <= 1'b1;
        end
    end

    // ******************************************************
    // event routing into the banks
    // ******************************************************
    always_comb begin
        low_if.set_evt = '0;
        low_if.set_evt[REACT_SIGN_BIT] = react_sign_chg;
        low_if.set_evt[ACT_SIGN_BIT] = act_sign_chg;
        low_if.set_evt[APP_NOLOAD_BIT] = apparent_noload_flag | irms_noload_enter;
        low_if.set_evt[REACT_NOLOAD_BIT] = reactive_noload_flag;
        low_if.set_evt[ACT_NOLOAD_BIT] = active_noload_flag;
    end

    // pulse flags set regardless of whether the output pin is enabled
    always_comb begin
        mid_if.set_evt = '0;
        mid_if.set_evt[FREQ_B_BIT] = freq_out_b_pulse;
        mid_if.set_evt[FREQ_A_BIT] = freq_out_a_pulse;
        mid_if.set_evt[APP_OVF_BIT] = apparent_energy_overflow;
        mid_if.set_evt[REACT_OVF_BIT] = reactive_energy_overflow;
        mid_if.set_evt[ACT_OVF_BIT] = active_energy_overflow;
        mid_if.set_evt[APP_HALF_BIT] = apparent_energy_half;
        mid_if.set_evt[REACT_HALF_BIT] = reactive_energy_half;
        mid_if.set_evt[ACT_HALF_BIT] = active_energy_half;
    end

    always_comb begin
        high_if.set_evt = '0;
        high_if.set_evt[RESET_DONE_BIT] = !boot_seen_q | soft_reset_done;
        high_if.set_evt[WAVE_READY_BIT] = waveform_sample_ready;
        high_if.set_evt[CUR_PEAK_BIT] = current_peak_flag;
        high_if.set_evt[VOLT_PEAK_BIT] = voltage_peak_flag;
        high_if.set_evt[CYCLE_DONE_BIT] = cycle_accum_done;
        high_if.set_evt[ZX_TIMEOUT_BIT] = zero_cross_timeout;
        high_if.set_evt[ZX_BIT] = zero_cross_flag;
    end

    // writing a zero clears a flag, writing a one leaves it alone
    assign low_if.clr_req = wr_status_low ? ~reg_wdata : '0;
    assign mid_if.clr_req = wr_status_mid ? ~reg_wdata : '0;
    assign high_if.clr_req = wr_status_high ? ~reg_wdata : '0;

    assign low_if.keep_mask = LOW_KEEP;
    assign mid_if.keep_mask = MID_KEEP;
    assign high_if.keep_mask = HIGH_STATUS_MASK;
    assign low_if.enable = enable_low_q;
    assign mid_if.enable = enable_mid_q;
    assign high_if.enable = enable_high_q;

    // ******************************************************
    // flag banks
    // ******************************************************
    irq_flag_bank #(.WIDTH(8)) u_low_bank (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .bank(low_if)
    );

    irq_flag_bank #(.WIDTH(8)) u_mid_bank (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .bank(mid_if)
    );

    irq_flag_bank #(.WIDTH(8)) u_high_bank (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .bank(high_if)
    );

    // ******************************************************
    // summary and interrupt line
    // ******************************************************
    // no stored copy: the summary drops the cycle the last enabled flag clears
    assign summary = low_if.pend_any | mid_if.pend_any | high_if.pend_any;
    assign meas_irq_pending = summary;

    // ******************************************************
    // read path
    // ******************************************************
    always_comb begin
        rdata_d = READ_IDLE;
        case (reg_addr)
            ADDR_ACCUM_MODE: rdata_d = accum_mode_q;
            ADDR_ENABLE_LOW: rdata_d = enable_low_q;
            ADDR_ENABLE_MID: rdata_d = enable_mid_q;
            ADDR_ENABLE_HIGH: rdata_d = enable_high_q;
            ADDR_STATUS_LOW: begin
                rdata_d = low_if.flags & LOW_KEEP;
                rdata_d[SUMMARY_BIT] = summary;
            end
            ADDR_STATUS_MID: rdata_d = mid_if.flags & MID_KEEP;
            ADDR_STATUS_HIGH: rdata_d = high_if.flags & HIGH_STATUS_MASK;
            default: rdata_d = READ_IDLE;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= READ_IDLE;
        end else if (ce) begin
            rdata_q <= reg_rd ? rdata_d : READ_IDLE;
        end
    end

    assign reg_rdata = rdata_q;

    // ******************************************************
    // checks
    // ******************************************************
    chk_summary_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && reg_rd && (reg_addr == ADDR_STATUS_LOW) |=> reg_rdata[SUMMARY_BIT] == $past(meas_irq_pending))
        else $error("summary bit read differs from pending line");

    chk_summary_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((low_if.flags & enable_low_q) == '0) && ((mid_if.flags & enable_mid_q) == '0) &&
        ((high_if.flags & enable_high_q) == '0) |-> !meas_irq_pending)
        else $error("pending stays high with no enabled flag");

    chk_line_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_low_q[ACT_NOLOAD_BIT] && low_if.flags[ACT_NOLOAD_BIT] |-> meas_irq_pending)
        else $error("enabled flag does not raise pending line");

    chk_sign_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        act_sign_chg |=> low_if.flags[ACT_SIGN_BIT])
        else $error("active sign change not flagged");

    chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && !wr_status_mid |=> (mid_if.flags & $past(mid_if.flags)) == $past(mid_if.flags))
        else $error("mid flag dropped without a clear");

    chk_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_status_high && !reg_wdata[ZX_BIT] && zero_cross_flag |=> high_if.flags[ZX_BIT])
        else $error("event lost against a same-cycle clear");

    chk_reset_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && !boot_seen_q |=> high_if.flags[RESET_DONE_BIT])
        else $error("end of reset not flagged");

    chk_wave_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_high_q[WAVE_READY_BIT] && high_if.flags[WAVE_READY_BIT] && !reg_wr
        |-> meas_irq_pending ##1 meas_irq_pending)
        else $error("waveform interrupt dropped early");

    chk_reactive_inert: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !HAS_REACTIVE |-> !low_if.flags[REACT_SIGN_BIT] && !mid_if.flags[REACT_OVF_BIT] &&
        !enable_low_q[REACT_NOLOAD_BIT])
        else $error("reactive bit alive on reduced variant");

    chk_read_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && !reg_rd |=> reg_rdata == READ_IDLE)
        else $error("read data outside the answer cycle");

    chk_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ce |=> $stable(low_if.flags) && $stable(high_if.flags) && $stable(enable_mid_q))
        else $error("state moved with clock enable low");

    // every bank must reach the line on its own, or one missing term goes unseen
    chk_low_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (low_if.flags & enable_low_q) != '0 |-> meas_irq_pending)
        else $error("enabled low flag does not raise pending line");

    chk_mid_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mid_if.flags & enable_mid_q) != '0 |-> meas_irq_pending)
        else $error("enabled mid flag does not raise pending line");

    chk_high_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (high_if.flags & enable_high_q) != '0 |-> meas_irq_pending)
        else $error("enabled high flag does not raise pending line");

    chk_zx_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && zero_cross_flag |=> high_if.flags[ZX_BIT])
        else $error("zero crossing not flagged");

    chk_pulse_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && freq_out_b_pulse |=> mid_if.flags[FREQ_B_BIT])
        else $error("frequency output pulse not flagged");

    chk_reserved_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && reg_rd && (reg_addr == ADDR_STATUS_LOW) |=> reg_rdata[6:5] == 2'b00)
        else $error("reserved low status bits read nonzero");
endmodule // metering_interrupt_flags

// ===== logic/sign_change_detect.sv
`timescale 1ns/100ps
module sign_change_detect (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sample_valid,
    input wire logic sign_neg,
    input wire logic rise_to_pos,
    output logic change_strobe
);
    logic prev_neg_q;
    logic primed_q;

    // remember the last sign; the first sample only primes the history
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_neg_q <= 1'b0;
            primed_q <= 1'b0;
        end else if (ce && sample_valid) begin
            prev_neg_q <= sign_neg;
            primed_q <= 1'b1;
        end
    end

    // cfg 0 fires on going negative, cfg 1 on going positive
    assign change_strobe = ce && sample_valid && primed_q && (sign_neg != prev_neg_q) &&
        (sign_neg == !rise_to_pos);
endmodule // sign_change_detect

// ===== verification/irq_core_model.sv
`timescale 1ns/100ps
// ****
// core-side interrupt sampling
// ****
module irq_core_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic irq_line,
    output logic irq_seen_q
);
    // level-sensitive: a request is seen for as long as the line stands
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_seen_q <= 1'b0;
        end else begin
            irq_seen_q <= irq_line;
        end
    end
endmodule // irq_core_model

// ===== verification/tb_metering_interrupt_flags.sv
`timescale 1ns/100ps
module tb_metering_interrupt_flags;
    import meter_irq_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    byte_t reg_addr = 8'h00;
    byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    byte_t reg_rdata;
    byte_t cfg_out;
    byte_t rv;
    logic psv = 1'b0;
    logic act_neg = 1'b0;
    logic react_neg = 1'b0;
    logic [18:0] evt = '0;
    logic pending;
    logic core_seen;
    byte_t lite_rdata;
    byte_t lite_rv;
    logic lite_pending;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    // event index to status address and bit, in port order below
    localparam byte_t EV_ADDR [19] = '{8'hDC, 8'hDC, 8'hDC, 8'hDC, 8'hDD, 8'hDD, 8'hDD, 8'hDD, 8'hDD, 8'hDD,
        8'hDD, 8'hDD, 8'hDE, 8'hDE, 8'hDE, 8'hDE, 8'hDE, 8'hDE, 8'hDE};
    localparam int EV_BIT [19] = '{2, 2, 1, 0, 6, 7, 5, 4, 3, 2, 1, 0, 7, 5, 4, 3, 2, 1, 0};

    metering_interrupt_flags u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_sign_valid(psv), .active_power_neg(act_neg), .reactive_power_neg(react_neg),
        .apparent_noload_flag(evt[0]), .irms_noload_enter(evt[1]), .reactive_noload_flag(evt[2]),
        .active_noload_flag(evt[3]), .freq_out_a_pulse(evt[4]), .freq_out_b_pulse(evt[5]),
        .apparent_energy_overflow(evt[6]), .reactive_energy_overflow(evt[7]), .active_energy_overflow(evt[8]),
        .apparent_energy_half(evt[9]), .reactive_energy_half(evt[10]), .active_energy_half(evt[11]),
        .soft_reset_done(evt[12]), .waveform_sample_ready(evt[13]), .current_peak_flag(evt[14]),
        .voltage_peak_flag(evt[15]), .cycle_accum_done(evt[16]), .zero_cross_timeout(evt[17]),
        .zero_cross_flag(evt[18]), .accumulation_mode_cfg(cfg_out), .meas_irq_pending(pending));
    irq_core_model u_core (.ref_clk(ref_clk), .rst_n(rst_n), .irq_line(pending), .irq_seen_q(core_seen));
    // reduced variant on the same bus and events: reactive bits must stay dead
    metering_interrupt_flags #(.HAS_REACTIVE(1'b0)) u_lite (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(lite_rdata),
        .power_sign_valid(psv), .active_power_neg(act_neg), .reactive_power_neg(react_neg),
        .apparent_noload_flag(evt[0]), .irms_noload_enter(evt[1]), .reactive_noload_flag(evt[2]),
        .active_noload_flag(evt[3]), .freq_out_a_pulse(evt[4]), .freq_out_b_pulse(evt[5]),
        .apparent_energy_overflow(evt[6]), .reactive_energy_overflow(evt[7]), .active_energy_overflow(evt[8]),
        .apparent_energy_half(evt[9]), .reactive_energy_half(evt[10]), .active_energy_half(evt[11]),
        .soft_reset_done(evt[12]), .waveform_sample_ready(evt[13]), .current_peak_flag(evt[14]),
        .voltage_peak_flag(evt[15]), .cycle_accum_done(evt[16]), .zero_cross_timeout(evt[17]),
        .zero_cross_flag(evt[18]), .accumulation_mode_cfg(), .meas_irq_pending(lite_pending));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // ****
    // shared tasks
    // ****
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // a hang in any handshake ends up here instead of running forever
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    task automatic cmp8(input string what, input byte_t exp, input byte_t got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wr(input byte_t a, input byte_t d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input byte_t a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        rv = reg_rdata;
        lite_rv = lite_rdata;
    endtask
    task automatic pulse(input int i);
        @(posedge ref_clk);
        evt[i] <= 1'b1;
        @(posedge ref_clk);
        evt <= '0;
        @(negedge ref_clk);
    endtask
    task automatic sign(input logic a, input logic r);
        @(posedge ref_clk);
        psv <= 1'b1;
        act_neg <= a;
        react_neg <= r;
        @(posedge ref_clk);
        psv <= 1'b0;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        rd(ADDR_STATUS_HIGH);
        cmp8("status_high", 8'h80, rv);
        rd(ADDR_ENABLE_HIGH);
        cmp8("enable_high", ENABLE_RESET, rv);
        cmp1("pending", 1'b0, pending);
        wr(ADDR_STATUS_HIGH, 8'h7F);
        rd(ADDR_STATUS_HIGH);
        cmp8("status_high", 8'h00, rv);
        $display("test reset finished");
    endtask
    task automatic t_events();
        byte_t a;
        byte_t m;
        byte_t ea;
        byte_t msk;
        logic p;
        for (int i = 0; i < 19; i++) begin
            a = EV_ADDR[i];
            m = 8'h01 << EV_BIT[i];
            ea = a - 8'h03;
            msk = (a == ADDR_STATUS_LOW) ? LOW_VALID_MASK : (a == ADDR_STATUS_MID) ? MID_VALID_MASK : HIGH_ENABLE_MASK;
            p = |(m & msk);
            pulse(i);
            rd(a);
            cmp8("status", m, rv);
            cmp8("status_lite", (i == 2 || i == 7 || i == 10) ? 8'h00 : m, lite_rv);
            cmp1("pending", 1'b0, pending);
            wr(ea, m);
            rd(ea);
            cmp8("enable", m & msk, rv);
            cmp1("pending", p, pending);
            cmp1("pending_lite", (i == 2 || i == 7 || i == 10) ? 1'b0 : p, lite_pending);
            rd(a);
            cmp8("status", (a == ADDR_STATUS_LOW && p) ? (m | 8'h80) : m, rv);
            wr(a, ~m);
            @(negedge ref_clk);
            cmp1("pending", 1'b0, pending);
            rd(a);
            cmp8("status", 8'h00, rv);
            wr(ea, 8'h00);
        end
        $display("test events finished");
    endtask
    task automatic t_sign();
        sign(1'b0, 1'b0);
        sign(1'b1, 1'b0);
        rd(ADDR_STATUS_LOW);
        cmp8("status_low", 8'h08, rv);
        wr(ADDR_STATUS_LOW, 8'h00);
        wr(ADDR_ACCUM_MODE, 8'hFF);
        rd(ADDR_ACCUM_MODE);
        cmp8("accum_cfg", ACCUM_MODE_MASK, rv);
        cmp8("accum_port", ACCUM_MODE_MASK, cfg_out);
        sign(1'b0, 1'b1);
        rd(ADDR_STATUS_LOW);
        cmp8("status_low", 8'h08, rv);
        wr(ADDR_STATUS_LOW, 8'h00);
        sign(1'b0, 1'b0);
        rd(ADDR_STATUS_LOW);
        cmp8("status_low", 8'h10, rv);
        wr(ADDR_STATUS_LOW, 8'h00);
        $display("test sign finished");
    endtask
    task automatic t_hold();
        wr(ADDR_ENABLE_HIGH, 8'h20);
        pulse(13);
        repeat (5) @(negedge ref_clk);
        cmp1("pending", 1'b1, pending);
        cmp1("core_seen", 1'b1, core_seen);
        // an event landing with the clear must survive it
        @(posedge ref_clk);
        evt[13] <= 1'b1;
        reg_wr <= 1'b1;
        reg_addr <= ADDR_STATUS_HIGH;
        reg_wdata <= 8'hDF;
        @(posedge ref_clk);
        evt <= '0;
        reg_wr <= 1'b0;
        rd(ADDR_STATUS_HIGH);
        cmp8("status_high", 8'h20, rv);
        wr(ADDR_STATUS_HIGH, 8'hDF);
        rd(ADDR_STATUS_HIGH);
        cmp8("status_high", 8'h00, rv);
        cmp1("core_seen", 1'b0, core_seen);
        wr(ADDR_ENABLE_HIGH, 8'h00);
        $display("test hold finished");
    endtask
    task automatic t_bus();
        rd(8'hE0);
        cmp8("unmapped", READ_IDLE, rv);
        wr(ADDR_ENABLE_LOW, 8'hFF);
        rd(ADDR_ENABLE_LOW);
        cmp8("enable_low", LOW_VALID_MASK, rv);
        wr(ADDR_STATUS_LOW, 8'hFF);
        rd(ADDR_STATUS_LOW);
        cmp8("status_low", 8'h00, rv);
        @(negedge ref_clk);
        cmp8("rdata_idle", READ_IDLE, reg_rdata);
        @(posedge ref_clk);
        ce <= 1'b0;
        pulse(18);
        @(posedge ref_clk);
        ce <= 1'b1;
        rd(ADDR_STATUS_HIGH);
        cmp8("status_high", 8'h00, rv);
        wr(ADDR_ENABLE_LOW, 8'h00);
        $display("test bus finished");
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_events();
        t_sign();
        t_hold();
        t_bus();
        summarize();
    end
endmodule // tb_metering_interrupt_flags
